// ---- aux_adc_pkg.sv ----
// constants, register map and carrier types of the auxiliary converter sequencer
// assumes a 10 MHz reference clock and a 32-bit APB register bus
package aux_adc_pkg;

    // converter geometry
    localparam int CHANNELS = 4;
    localparam int CHANNEL_W = 2;
    localparam int RESULT_W = 9;

    // timing: one period T is one reference clock cycle
    localparam int CLOCK_NS = 100;
    localparam int T_NS = 100;
    localparam int START_DELAY_T = 2;
    localparam int READY_DELAY_T = 9;
    localparam int START_CYCLES = (START_DELAY_T * T_NS) / CLOCK_NS;
    localparam int READY_CYCLES = (READY_DELAY_T * T_NS) / CLOCK_NS;
    localparam int TIMEOUT_CYCLES = 4 * READY_CYCLES;
    localparam int COUNT_W = 8;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] RESULT_BASE = 8'h08;

    // control field positions
    localparam int ENABLE_BIT = 0;
    localparam int SELECT_LSB = 1;

    // status field positions
    localparam int VALID_LSB = 0;
    localparam int BUSY_BIT = 4;
    localparam int TIMEOUT_BIT = 5;

    // reset values
    localparam logic [CHANNEL_W-1:0] SELECT_RESET = 2'h0;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 9'h000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DELAY = 3'b010,
        ST_CONVERT = 3'b100
    } seq_state_t;

    // towards the converter macro
    typedef struct packed {
        logic start;
        logic [CHANNEL_W-1:0] channel;
    } conv_req_t;

    // from the converter macro
    typedef struct packed {
        logic ready;
        logic [RESULT_W-1:0] data;
    } conv_rsp_t;

endpackage

// ---- aux_adc_sequencer.sv ----
// sequencer for a four-channel auxiliary converter, with an APB register slave
// assumes the converter macro answers each start with one ready pulse and data
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// - four inputs exist; a single selected channel converts at a time
// - every result captured and held for software is nine bits
// - the software channel field decides which input gets converted
// - setting enable makes hardware issue the start strobe two periods later
// - ready sets a readable valid flag for the converted channel
module aux_adc_sequencer #(
    parameter int ADDR_W = 8
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output aux_adc_pkg::conv_req_t conv_req_out,
    input wire aux_adc_pkg::conv_rsp_t conv_rsp_in
);

    aux_adc_pkg::seq_state_t state_reg;
    logic enable_reg;
    logic [aux_adc_pkg::CHANNEL_W-1:0] channel_select_reg;
    logic [aux_adc_pkg::CHANNEL_W-1:0] active_channel_reg;
    logic [aux_adc_pkg::CHANNELS-1:0] channel_result_valid_reg;
    logic timeout_reg;
    logic start_reg;
    logic [aux_adc_pkg::COUNT_W-1:0] count_reg;
    logic [aux_adc_pkg::RESULT_W-1:0] result_reg [aux_adc_pkg::CHANNELS];
    logic [31:0] prdata_reg;

    logic setup_phase;
    logic write_access;
    logic ctrl_write;
    logic status_write;
    logic start_go;
    logic capture;
    logic expire;
    logic [aux_adc_pkg::CHANNEL_W-1:0] channel_next;

    // true when the word address names a register
    function automatic logic map_hit(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = 8'(addr);
        map_hit = (a == aux_adc_pkg::CTRL_OFFSET) ||
                  (a == aux_adc_pkg::STATUS_OFFSET) ||
                  ((a >= aux_adc_pkg::RESULT_BASE) &&
                   (a < 8'(aux_adc_pkg::RESULT_BASE + 8'(4 * aux_adc_pkg::CHANNELS))) &&
                   (a[1:0] == 2'h0));
    endfunction

    // read data of one register
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        logic [7:0] rel;
        a = 8'(addr);
        rel = 8'(a - aux_adc_pkg::RESULT_BASE);
        read_word = 32'h0000_0000;
        if (a == aux_adc_pkg::CTRL_OFFSET) begin
            read_word[aux_adc_pkg::ENABLE_BIT] = enable_reg;
            read_word[aux_adc_pkg::SELECT_LSB +: aux_adc_pkg::CHANNEL_W] =
                channel_select_reg;
        end else if (a == aux_adc_pkg::STATUS_OFFSET) begin
            read_word[aux_adc_pkg::VALID_LSB +: aux_adc_pkg::CHANNELS] =
                channel_result_valid_reg;
            read_word[aux_adc_pkg::BUSY_BIT] = (state_reg != aux_adc_pkg::ST_IDLE);
            read_word[aux_adc_pkg::TIMEOUT_BIT] = timeout_reg;
        end else if (map_hit(addr)) begin
            read_word[aux_adc_pkg::RESULT_W-1:0] =
                result_reg[rel[aux_adc_pkg::CHANNEL_W+1:2]];
        end
    endfunction

    // apb: zero wait states, read data captured in the setup cycle
    assign setup_phase = psel_in && !penable_in;
    assign write_access = psel_in && penable_in && pwrite_in;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !map_hit(paddr_in);
    assign prdata_out = prdata_reg;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase && !pwrite_in) begin
            prdata_reg <= read_word(paddr_in);
        end
    end

    assign ctrl_write = write_access && (8'(paddr_in) == aux_adc_pkg::CTRL_OFFSET);
    assign status_write = write_access && (8'(paddr_in) == aux_adc_pkg::STATUS_OFFSET);
    assign channel_next = pwdata_in[aux_adc_pkg::SELECT_LSB +: aux_adc_pkg::CHANNEL_W];

    // a conversion only starts from idle
    assign start_go = ctrl_write && pwdata_in[aux_adc_pkg::ENABLE_BIT] &&
                      (state_reg == aux_adc_pkg::ST_IDLE);
    assign capture = (state_reg == aux_adc_pkg::ST_CONVERT) && conv_rsp_in.ready;
    assign expire = (state_reg == aux_adc_pkg::ST_CONVERT) && !conv_rsp_in.ready &&
                    (count_reg == 8'(aux_adc_pkg::TIMEOUT_CYCLES - 1));

    // channel field, free to change at any time
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            channel_select_reg <= aux_adc_pkg::SELECT_RESET;
        end else if (ctrl_write) begin
            channel_select_reg <= channel_next;
        end
    end

    // enable stays set until the conversion ends
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            enable_reg <= 1'b0;
        end else if (start_go) begin
            enable_reg <= 1'b1;
        end else if (capture || expire) begin
            enable_reg <= 1'b0;
        end
    end

    // sequence: delay, strobe, wait for ready
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_reg <= aux_adc_pkg::ST_IDLE;
            count_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                aux_adc_pkg::ST_IDLE: begin
                    if (start_go) begin
                        state_reg <= aux_adc_pkg::ST_DELAY;
                        count_reg <= 8'(aux_adc_pkg::START_CYCLES - 1);
                    end
                end
                aux_adc_pkg::ST_DELAY: begin
                    if (count_reg == 8'h00) begin
                        state_reg <= aux_adc_pkg::ST_CONVERT;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                aux_adc_pkg::ST_CONVERT: begin
                    if (capture || expire) begin
                        state_reg <= aux_adc_pkg::ST_IDLE;
                        count_reg <= 8'h00;
                    end else begin
                        count_reg <= count_reg + 8'h01;
                    end
                end
                default: begin
                    state_reg <= aux_adc_pkg::ST_IDLE;
                    count_reg <= 8'h00;
                end
            endcase
        end
    end

    // one-cycle start strobe
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= (state_reg == aux_adc_pkg::ST_DELAY) && (count_reg == 8'h00);
        end
    end

    // channel latched at start, held for the whole conversion
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            active_channel_reg <= aux_adc_pkg::SELECT_RESET;
        end else if (start_go) begin
            active_channel_reg <= channel_next;
        end
    end

    assign conv_req_out = '{start: start_reg, channel: active_channel_reg};

    // results, one nine-bit word per channel
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            for (int i = 0; i < aux_adc_pkg::CHANNELS; i++) begin
                result_reg[i] <= aux_adc_pkg::RESULT_RESET;
            end
        end else if (capture) begin
            result_reg[active_channel_reg] <= conv_rsp_in.data;
        end
    end

    // valid flags: cleared at start or by writing one, set wins
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            channel_result_valid_reg <= '0;
        end else begin
            for (int i = 0; i < aux_adc_pkg::CHANNELS; i++) begin
                if (capture && (active_channel_reg == 2'(i))) begin
                    channel_result_valid_reg[i] <= 1'b1;
                end else if ((start_go && (channel_next == 2'(i))) ||
                             (status_write && pwdata_in[aux_adc_pkg::VALID_LSB + i])) begin
                    channel_result_valid_reg[i] <= 1'b0;
                end
            end
        end
    end

    // timeout flag when ready never comes
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            timeout_reg <= 1'b0;
        end else if (expire) begin
            timeout_reg <= 1'b1;
        end else if (start_go ||
                     (status_write && pwdata_in[aux_adc_pkg::TIMEOUT_BIT])) begin
            timeout_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);

    a_start_two_cycles: assert property (
        start_go |=> !start_reg ##1 !start_reg ##1 start_reg)
        else $error("start strobe not two cycles after enable");

    a_strobe_one_cycle: assert property (
        start_reg |=> !start_reg)
        else $error("start strobe longer than one cycle");

    a_state_onehot: assert property (
        $onehot(state_reg))
        else $error("sequencer state not one-hot");

    a_channel_held: assert property (
        (state_reg != aux_adc_pkg::ST_IDLE) && !start_go |=> $stable(active_channel_reg))
        else $error("converted channel changed mid conversion");

    a_channel_follows: assert property (
        start_go |=> active_channel_reg == $past(channel_next))
        else $error("converted channel differs from written field");

    a_valid_raised: assert property (
        capture |=> channel_result_valid_reg[$past(active_channel_reg)])
        else $error("valid flag not set on ready");

    a_result_stored: assert property (
        capture |=> result_reg[$past(active_channel_reg)] == $past(conv_rsp_in.data))
        else $error("result not stored on ready");

    a_wait_ready: assert property (
        start_reg && !conv_rsp_in.ready |=> (state_reg == aux_adc_pkg::ST_CONVERT) && enable_reg)
        else $error("conversion ended before ready");

    a_start_in_convert: assert property (
        start_reg |-> state_reg == aux_adc_pkg::ST_CONVERT)
        else $error("start strobe outside conversion state");

    a_start_has_enable: assert property (
        $rose(start_reg) |-> enable_reg)
        else $error("start strobe without enable set");

    a_start_channel_steady: assert property (
        start_reg |-> $stable(conv_req_out.channel))
        else $error("channel moved while strobe raised");

    a_delay_two_cycles: assert property (
        $rose(state_reg == aux_adc_pkg::ST_DELAY) |->
            (state_reg == aux_adc_pkg::ST_DELAY) [*2] ##1 (state_reg == aux_adc_pkg::ST_CONVERT))
        else $error("start delay not two clock cycles");

    a_delay_count_range: assert property (
        (state_reg == aux_adc_pkg::ST_DELAY) |-> count_reg < 8'(aux_adc_pkg::START_CYCLES))
        else $error("delay counter out of range");

    a_convert_bounded: assert property (
        $rose(state_reg == aux_adc_pkg::ST_CONVERT) |-> ##[1:36] state_reg == aux_adc_pkg::ST_IDLE)
        else $error("conversion did not end within timeout");

    a_capture_ends: assert property (
        capture |=> (state_reg == aux_adc_pkg::ST_IDLE) && !enable_reg)
        else $error("conversion not closed on ready");

    a_expire_flags: assert property (
        expire |=> timeout_reg && (state_reg == aux_adc_pkg::ST_IDLE) && !enable_reg)
        else $error("timeout not flagged on missing ready");

    a_timeout_from_expire: assert property (
        $rose(timeout_reg) |-> $past(expire))
        else $error("timeout flag raised without expiry");

    a_valid_cleared_start: assert property (
        start_go |=> !channel_result_valid_reg[$past(channel_next)])
        else $error("valid flag not cleared at start");

    a_valid_from_capture: assert property (
        (channel_result_valid_reg & ~$past(channel_result_valid_reg)) != 4'h0 |-> $past(capture))
        else $error("valid flag raised without ready");

endmodule

// ---- aux_adc_macro_model.sv ----
// behavioural model of the analogue converter macro facing the sequencer
// assumes one start pulse per conversion; latency and silence set by the bench
`timescale 1ns/1ps

module aux_adc_macro_model (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire aux_adc_pkg::conv_req_t conv_req_in,
    input wire logic [7:0] latency_in,
    input wire logic mute_in,
    output aux_adc_pkg::conv_rsp_t conv_rsp_out
);
    logic busy_reg;
    logic [7:0] count_reg;
    logic [1:0] channel_reg;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            busy_reg <= 1'b0;
            count_reg <= 8'h00;
            channel_reg <= 2'h0;
            conv_rsp_out <= '0;
        end else begin
            conv_rsp_out.ready <= 1'b0;
            // data wanders outside the ready cycle
            conv_rsp_out.data <= ~conv_rsp_out.data;
            if (conv_req_in.start && !mute_in) begin
                busy_reg <= 1'b1;
                count_reg <= latency_in;
                channel_reg <= conv_req_in.channel;
            end else if (busy_reg) begin
                if (count_reg <= 8'h01) begin
                    busy_reg <= 1'b0;
                    conv_rsp_out.ready <= 1'b1;
                    conv_rsp_out.data <= 9'h0C3 + {1'b0, channel_reg, 6'h00};
                end else begin
                    count_reg <= count_reg - 8'h01;
                end
            end
        end
    end
endmodule

// ---- aux_adc_sequencer_tb.sv ----
// self-checking bench of the converter sequencer over APB
// assumes the converter model beside the design and a 10 MHz clock
`timescale 1ns/1ps

module aux_adc_sequencer_tb;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    aux_adc_pkg::conv_req_t conv_req;
    aux_adc_pkg::conv_rsp_t conv_rsp;
    logic [7:0] latency = 8'h09;
    logic mute = 1'b0;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic er;
    int waits = 0;
    // each row: converter latency, then the result it should yield
    logic [16:0] rows [4] = '{{8'h09, 9'h0C3}, {8'h09, 9'h103}, {8'h01, 9'h143},
        {8'h14, 9'h183}};

    aux_adc_sequencer DUT (.clock_in(clock_in), .reset_in(reset_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .conv_req_out(conv_req), .conv_rsp_in(conv_rsp));
    aux_adc_macro_model conv (.clock_in(clock_in), .reset_in(reset_in), .conv_req_in(conv_req),
        .latency_in(latency), .mute_in(mute), .conv_rsp_out(conv_rsp));

    initial begin
        forever #50 clock_in = ~clock_in;
    end

    task automatic test_done();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wdata;
        @(posedge clock_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        rd = prdata_out;
        er = pslverr_out;
        waits = n;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, aux_adc_pkg::STATUS_OFFSET, 32'h0);
            n++;
        end while (rd[aux_adc_pkg::BUSY_BIT] !== 1'b0 && n < 60);
    endtask

    initial begin
        repeat (20000) @(posedge clock_in);
        err_total++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge clock_in);
        reset_in <= 1'b0;
        for (int ch = 0; ch < aux_adc_pkg::CHANNELS; ch++) begin
            latency <= rows[ch][16:9];
            apb(1'b1, aux_adc_pkg::CTRL_OFFSET, 32'(ch * 2 + 1));
            chk(32'(waits), 32'h1);
            for (int i = 0; i < 4; i++) begin
                @(negedge clock_in);
                chk(32'(conv_req.start), 32'(i == 2));
            end
            chk(32'(conv_req.channel), 32'(ch));
            wait_idle();
            chk(rd, 32'(1) << ch);
            apb(1'b0, aux_adc_pkg::RESULT_BASE + 8'(ch * 4), 32'h0);
            chk(rd, 32'(rows[ch][8:0]));
            chk(32'(er), 32'h0);
            apb(1'b1, aux_adc_pkg::STATUS_OFFSET, 32'(1) << ch);
            apb(1'b0, aux_adc_pkg::CTRL_OFFSET, 32'h0);
            chk(rd, 32'(ch * 2));
        end
        mute <= 1'b1;
        apb(1'b1, aux_adc_pkg::CTRL_OFFSET, 32'h3);
        // enable while busy must not restart; only the channel field moves
        apb(1'b1, aux_adc_pkg::CTRL_OFFSET, 32'h5);
        chk(32'(conv_req.channel), 32'h1);
        wait_idle();
        chk(rd, 32'h20);
        apb(1'b0, aux_adc_pkg::CTRL_OFFSET, 32'h0);
        chk(rd, 32'h4);
        mute <= 1'b0;
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        reset_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        apb(1'b0, aux_adc_pkg::STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, aux_adc_pkg::RESULT_BASE + 8'h0C, 32'h0);
        chk(rd, 32'h0);
        test_done();
    end
endmodule
